// *** core/drive_map.svh ***
// Register indices, reset values and fixed codes of the cyclic command mapper.
`ifndef DRIVE_MAP_SVH
`define DRIVE_MAP_SVH

`define ADDR_CFG 4'h0
`define ADDR_ACTIVE 4'h1
`define ADDR_FREQ 4'h2
`define ADDR_STAT 4'h3

`define CFG_RST 16'h0000
`define CFG_EXT_LSB 0
`define CFG_EXT_MSB 7
`define CFG_SIGNED_BIT 8
`define CFG_SPEED_BIT 9

`define FREQ_RST 16'h0000
`define FREQ_MAX_HZ 16'hE678
`define ERR_NONE 8'h00
`define ERR_WRITE_MODE 8'h01

`define EXT_RST 8'h00
`define EXT_0 8'h00
`define EXT_1 8'h01
`define EXT_12 8'h0C
`define EXT_14 8'h0E
`define EXT_18 8'h12
`define EXT_100 8'h64
`define EXT_112 8'h70
`define EXT_114 8'h72
`define EXT_118 8'h76

`endif

// *** core/drive_pkg.sv ***
// Types shared by the cyclic command mapper and its frequency decoder.
package drive_pkg;

	// First command word from the controller, bit 15 down to bit 0.
	typedef struct packed {
		logic instr_req;
		logic freq_set_nonvolatile_cmd;
		logic freq_set_ram_cmd;
		logic monitor_req;
		logic assignable_reset_function;
		logic assignable_input_2;
		logic output_stop;
		logic assignable_input_1;
		logic current_input_sel;
		logic second_function;
		logic jog_select;
		logic low_speed_select;
		logic middle_speed_select;
		logic high_speed_select;
		logic reverse_cmd;
		logic forward_cmd;
	} cmd_word1_s;

	// Second command word, bit 15 down to bit 0.
	typedef struct packed {
		logic [1:0] unused_hi;
		logic assignable_input_5;
		logic assignable_input_4;
		logic assignable_input_3;
		logic error_reset_req;
		logic [1:0] legacy_flags;
		logic [7:0] unused_lo;
	} cmd_word2_s;

	// Drive state presented to the mapper.
	typedef struct packed {
		logic forward_running;
		logic reverse_running;
		logic running;
		logic up_to_frequency;
		logic overload_warning;
		logic assignable_output_1;
		logic frequency_detection;
		logic fault_relay;
		logic assignable_output_2;
		logic digital_output_0;
		logic digital_output_1;
		logic digital_output_2;
		logic assignable_output_3;
		logic assignable_output_4;
		logic error_state;
		logic station_ready;
	} drive_state_s;

	// Commands handed to the drive functions.
	typedef struct packed {
		logic run_forward;
		logic run_reverse;
		logic high_speed_select;
		logic middle_speed_select;
		logic low_speed_select;
		logic jog_select;
		logic second_function;
		logic current_input_sel;
		logic output_stop;
		logic assignable_reset_function;
		logic [4:0] assignable_input;
	} drive_cmd_s;

	typedef enum logic [1:0] {
		FREQ_IDLE = 2'b00,
		FREQ_WRITE = 2'b01,
		FREQ_REJECT = 2'b10,
		FREQ_RANGE = 2'b11
	} freq_act_e;

endpackage

// *** core/freq_decoder.sv ***
// Decodes the frequency command word as unsigned or two's complement.
`timescale 1ns/10ps
`default_nettype none
`include "drive_map.svh"
module freq_decoder import drive_pkg::*; (
	// Word and mode
	input wire logic [15:0] i_word,
	input wire logic i_signed,
	input wire logic i_speed_en,
	// Result
	output logic [15:0] o_mag,
	output logic o_neg,
	output logic o_in_range
);
	always_comb begin
		o_neg = i_signed & i_word[15];
		o_mag = o_neg ? (~i_word + 16'h0001) : i_word;
		// The 590 Hz ceiling exists only for the unsigned frequency form.
		o_in_range = i_signed | i_speed_en | (i_word <= `FREQ_MAX_HZ);
	end
endmodule
`default_nettype wire

// *** core/drive_cyclic_command_mapper.sv ***
// Maps cyclic command and status words of a drive onto its functions.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "drive_map.svh"
// Notes on behaviour
// - Selections 0,1,12,14,18 give compatible registers; 100,112,114,118 add controller function.
// - A new register-extension selection takes effect only after reset.
// - Sign selection applies only to the frequency command word.
// - Unsigned 0..59000 as 0.01 Hz; signed is two's complement.
// - With speed display, unsigned 0..65535 or signed, in speed units.
// - Signed mode: a minus sign swaps the commanded rotation direction.
// - Signed mode: nonvolatile frequency write is rejected with error code 01.
// - Signed mode: RAM and nonvolatile requests together perform the RAM write.
// - After reset the sign is positive and set frequency is zero.
// - Instruction-code frequency writes keep the stored sign.
// - Command bits 0..4: forward, reverse, high, middle, low speed.
// - Command bits 5..B: jog, second, current, input 1, stop, input 2, reset.
// - Command bits C..F: monitor, RAM set, nonvolatile set, instruction request.
// - Status bits C..F answer those four requests.
// - Status bits 0..8 show run, direction, frequency, warning, fault, outputs.
// - Status bits 9..B show digital outputs; word 2 bits 6,7 outputs 3,4.
// - Second command word bits B..D are assignable inputs 3..5.
// - Error reset request on bit A; error and ready on status bits A,B.
// - Legacy flag bits 8,9 and reserved bits are ignored.
module drive_cyclic_command_mapper import drive_pkg::*; (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_drive_reset,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	// Cyclic words from the controller
	input wire cmd_word1_s i_cmd_word1,
	input wire cmd_word2_s i_cmd_word2,
	input wire logic [15:0] i_frequency_command_word,
	// Instruction-code frequency writes
	input wire logic i_instr_freq_wr,
	input wire logic [15:0] i_instr_freq_data,
	// Drive side
	input wire drive_state_s i_drive_state,
	output drive_cmd_s o_drive_cmd,
	output logic [15:0] o_set_freq,
	output logic o_freq_is_speed,
	output logic o_nv_store,
	output logic o_error_reset,
	output logic o_plc_enable,
	// Cyclic words to the controller
	output logic [15:0] o_status_word1,
	output logic [15:0] o_status_word2
);
	logic [15:0] cfg_ff;
	logic [7:0] ext_active_ff;
	logic ext_valid_ff;
	logic plc_ff;
	logic [15:0] freq_ff;
	logic sign_neg_ff;
	logic wm_err_ff;
	logic range_err_ff;
	logic [7:0] err_code_ff;
	logic [3:0] req_prev_ff;
	logic err_req_prev_ff;
	logic ram_done_ff;
	logic nv_done_ff;
	logic instr_done_ff;
	logic nv_store_ff;
	logic err_rst_ff;
	drive_cmd_s cmd_ff;
	logic [15:0] stat1_ff;
	logic [15:0] stat2_ff;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [15:0] dec_mag;
	logic dec_neg;
	logic dec_in_range;
	logic signed_mode;
	logic speed_mode;
	logic ram_edge;
	logic nv_edge;
	logic instr_edge;
	logic err_req_edge;
	logic nv_go;
	freq_act_e freq_act;

	assign signed_mode = cfg_ff[`CFG_SIGNED_BIT];
	assign speed_mode = cfg_ff[`CFG_SPEED_BIT];

	freq_decoder u_freq_decoder (
		.i_word(i_frequency_command_word),
		.i_signed(signed_mode),
		.i_speed_en(speed_mode),
		.o_mag(dec_mag),
		.o_neg(dec_neg),
		.o_in_range(dec_in_range)
	);

	// Requests act on their rising edge; a held request does nothing more.
	assign ram_edge = i_cmd_word1.freq_set_ram_cmd & ~req_prev_ff[1];
	assign nv_edge = i_cmd_word1.freq_set_nonvolatile_cmd & ~req_prev_ff[2];
	assign instr_edge = i_cmd_word1.instr_req & ~req_prev_ff[3];
	assign err_req_edge = i_cmd_word2.error_reset_req & ~err_req_prev_ff;
	// A nonvolatile request beside a live RAM request is served as RAM only.
	assign nv_go = nv_edge & ~i_cmd_word1.freq_set_ram_cmd;

	always_comb begin
		freq_act = FREQ_IDLE;
		if (ram_edge | nv_go) begin
			if (nv_go & signed_mode) begin
				freq_act = FREQ_REJECT;
			end else if (!dec_in_range) begin
				freq_act = FREQ_RANGE;
			end else begin
				freq_act = FREQ_WRITE;
			end
		end
	end

	// Configuration register; the extension selection waits here until reset.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			cfg_ff <= `CFG_RST;
		end else if (i_reg_wr && i_reg_addr == `ADDR_CFG) begin
			cfg_ff <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			ext_active_ff <= `EXT_RST;
			ext_valid_ff <= 1'b1;
			plc_ff <= 1'b0;
		end else if (i_drive_reset) begin
			ext_active_ff <= cfg_ff[`CFG_EXT_MSB:`CFG_EXT_LSB];
			case (cfg_ff[`CFG_EXT_MSB:`CFG_EXT_LSB])
				`EXT_0, `EXT_1, `EXT_12, `EXT_14, `EXT_18: begin
					ext_valid_ff <= 1'b1;
					plc_ff <= 1'b0;
				end
				`EXT_100, `EXT_112, `EXT_114, `EXT_118: begin
					ext_valid_ff <= 1'b1;
					plc_ff <= 1'b1;
				end
				default: begin
					ext_valid_ff <= 1'b0;
					plc_ff <= 1'b0;
				end
			endcase
		end
	end

	// Frequency and sign are never restored across a reset, so the motor
	// cannot restart at a speed the controller no longer intends.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst || i_drive_reset) begin
			freq_ff <= `FREQ_RST;
			sign_neg_ff <= 1'b0;
		end else if (freq_act == FREQ_WRITE) begin
			freq_ff <= dec_mag;
			sign_neg_ff <= dec_neg;
		end else if (i_instr_freq_wr) begin
			freq_ff <= i_instr_freq_data;
		end
	end

	// Error flags: a new error in the clearing cycle wins over the clear.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			wm_err_ff <= 1'b0;
			range_err_ff <= 1'b0;
			err_code_ff <= `ERR_NONE;
		end else if (freq_act == FREQ_REJECT) begin
			wm_err_ff <= 1'b1;
			err_code_ff <= `ERR_WRITE_MODE;
		end else if (freq_act == FREQ_RANGE) begin
			range_err_ff <= 1'b1;
		end else if (err_req_edge) begin
			wm_err_ff <= 1'b0;
			range_err_ff <= 1'b0;
			err_code_ff <= `ERR_NONE;
		end
	end

	// Completion flags stand until the controller drops its request.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			req_prev_ff <= 4'h0;
			err_req_prev_ff <= 1'b0;
			ram_done_ff <= 1'b0;
			nv_done_ff <= 1'b0;
			instr_done_ff <= 1'b0;
			nv_store_ff <= 1'b0;
			err_rst_ff <= 1'b0;
		end else begin
			req_prev_ff <= {i_cmd_word1.instr_req, i_cmd_word1.freq_set_nonvolatile_cmd,
				i_cmd_word1.freq_set_ram_cmd, i_cmd_word1.monitor_req};
			err_req_prev_ff <= i_cmd_word2.error_reset_req;
			ram_done_ff <= ram_edge | (ram_done_ff & i_cmd_word1.freq_set_ram_cmd);
			nv_done_ff <= nv_edge | (nv_done_ff & i_cmd_word1.freq_set_nonvolatile_cmd);
			instr_done_ff <= instr_edge | (instr_done_ff & i_cmd_word1.instr_req);
			nv_store_ff <= (freq_act == FREQ_WRITE) & nv_go;
			err_rst_ff <= err_req_edge;
		end
	end

	// Drive commands; the sign swaps direction only in signed mode.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			cmd_ff <= '0;
		end else begin
			cmd_ff.run_forward <= signed_mode && sign_neg_ff ?
				i_cmd_word1.reverse_cmd : i_cmd_word1.forward_cmd;
			cmd_ff.run_reverse <= signed_mode && sign_neg_ff ?
				i_cmd_word1.forward_cmd : i_cmd_word1.reverse_cmd;
			cmd_ff.high_speed_select <= i_cmd_word1.high_speed_select;
			cmd_ff.middle_speed_select <= i_cmd_word1.middle_speed_select;
			cmd_ff.low_speed_select <= i_cmd_word1.low_speed_select;
			cmd_ff.jog_select <= i_cmd_word1.jog_select;
			cmd_ff.second_function <= i_cmd_word1.second_function;
			cmd_ff.current_input_sel <= i_cmd_word1.current_input_sel;
			cmd_ff.output_stop <= i_cmd_word1.output_stop;
			cmd_ff.assignable_reset_function <= i_cmd_word1.assignable_reset_function;
			// Legacy flags and reserved bits of word 2 are never read here.
			cmd_ff.assignable_input <= {i_cmd_word2.assignable_input_5,
				i_cmd_word2.assignable_input_4, i_cmd_word2.assignable_input_3,
				i_cmd_word1.assignable_input_2, i_cmd_word1.assignable_input_1};
		end
	end

	// Status words; unlisted positions are built as zero.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			stat1_ff <= 16'h0000;
			stat2_ff <= 16'h0000;
		end else begin
			stat1_ff <= {instr_done_ff, nv_done_ff, ram_done_ff,
				i_cmd_word1.monitor_req & req_prev_ff[0],
				i_drive_state.digital_output_2, i_drive_state.digital_output_1,
				i_drive_state.digital_output_0, i_drive_state.assignable_output_2,
				i_drive_state.fault_relay, i_drive_state.frequency_detection,
				i_drive_state.assignable_output_1, i_drive_state.overload_warning,
				i_drive_state.up_to_frequency, i_drive_state.running,
				i_drive_state.reverse_running, i_drive_state.forward_running};
			stat2_ff <= {4'h0, i_drive_state.station_ready,
				i_drive_state.error_state | wm_err_ff | range_err_ff, 2'b00,
				i_drive_state.assignable_output_4, i_drive_state.assignable_output_3,
				6'h00};
		end
	end

	always_comb begin
		nxt_rdata = 16'h0000;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`ADDR_CFG: nxt_rdata = cfg_ff;
				`ADDR_ACTIVE: nxt_rdata = {6'h00, plc_ff, ext_valid_ff, ext_active_ff};
				`ADDR_FREQ: nxt_rdata = freq_ff;
				`ADDR_STAT: nxt_rdata = {err_code_ff, 4'h0, speed_mode, range_err_ff,
					wm_err_ff, sign_neg_ff};
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_drive_cmd = cmd_ff;
	assign o_set_freq = freq_ff;
	assign o_freq_is_speed = cfg_ff[`CFG_SPEED_BIT];
	assign o_nv_store = nv_store_ff;
	assign o_error_reset = err_rst_ff;
	assign o_plc_enable = plc_ff;
	assign o_status_word1 = stat1_ff;
	assign o_status_word2 = stat2_ff;

	sequence s_nv_alone_signed;
		nv_edge && !i_cmd_word1.freq_set_ram_cmd && signed_mode && !i_drive_reset;
	endsequence

	sequence s_both_signed;
		ram_edge && i_cmd_word1.freq_set_nonvolatile_cmd && signed_mode && dec_in_range
			&& !i_drive_reset;
	endsequence

	a_ext_apply_on_reset: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$changed(ext_active_ff) |-> $past(i_drive_reset))
		else $error("Extension selection applied without a reset.");

	a_ext_plc_decode: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_drive_reset && cfg_ff[`CFG_EXT_MSB:`CFG_EXT_LSB] == `EXT_112 |=> plc_ff && ext_valid_ff)
		else $error("Selection 112 did not enable the controller function.");

	a_nv_signed_reject: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_nv_alone_signed |=> wm_err_ff && err_code_ff == `ERR_WRITE_MODE && $stable(freq_ff)
			&& !o_nv_store)
		else $error("Signed nonvolatile write was not rejected.");

	a_ram_precedence: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_both_signed |=> freq_ff == $past(dec_mag) && !o_nv_store ##1 !o_nv_store)
		else $error("Combined request did not act as RAM only.");

	a_reset_clears_freq: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_drive_reset |=> freq_ff == `FREQ_RST && !sign_neg_ff)
		else $error("Drive reset kept frequency or sign.");

	a_instr_keeps_sign: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_instr_freq_wr && freq_act != FREQ_WRITE && !i_drive_reset |=> $stable(sign_neg_ff)
			&& freq_ff == $past(i_instr_freq_data))
		else $error("Instruction write changed the sign.");

	a_signed_direction: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		signed_mode && sign_neg_ff && i_cmd_word1.forward_cmd && !i_cmd_word1.reverse_cmd
			|=> o_drive_cmd.run_reverse && !o_drive_cmd.run_forward)
		else $error("Negative sign did not reverse forward command.");

	a_range_unsigned: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ram_edge && !signed_mode && !speed_mode && i_frequency_command_word > `FREQ_MAX_HZ
			&& !i_drive_reset |=> $stable(freq_ff) && range_err_ff)
		else $error("Out-of-range unsigned frequency was accepted.");

	a_ram_handshake: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ram_edge |=> ram_done_ff ##1 o_status_word1[13])
		else $error("RAM frequency completion not reported.");

	a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_status_word2[15:12] == 4'h0 && o_status_word2[9:8] == 2'b00
			&& o_status_word2[5:0] == 6'h00)
		else $error("Reserved status bit not zero.");

endmodule
`default_nettype wire

// *** tb/fieldbus_master_model.sv ***
// Behavioural controller that drives the cyclic command words and waits on status answers.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_master_model import drive_pkg::*; (
	// Clock
	input wire logic i_clk_sys,
	// Status from the device
	input wire logic [15:0] i_status_word1,
	// Cyclic words to the device
	output cmd_word1_s o_cmd_word1,
	output cmd_word2_s o_cmd_word2,
	output logic [15:0] o_frequency_command_word
);
	logic [15:0] base_ff;
	logic [15:0] req_ff;
	logic [15:0] w2_ff;
	logic [15:0] fw_ff;

	initial begin
		base_ff = 16'h0000;
		req_ff = 16'h0000;
		w2_ff = 16'h0000;
		fw_ff = 16'h0000;
	end

	// Request bits are kept apart so that a handshake never disturbs held command levels.
	assign o_cmd_word1 = cmd_word1_s'(base_ff | req_ff);
	assign o_cmd_word2 = cmd_word2_s'(w2_ff);
	assign o_frequency_command_word = fw_ff;

	task automatic set_words(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] fw);
		@(posedge i_clk_sys);
		base_ff <= w1;
		w2_ff <= w2;
		fw_ff <= fw;
	endtask

	// A request is held until its answer bit rises, then dropped until the answer clears.
	task automatic request(input logic [15:0] mask, input int ans, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge i_clk_sys);
		req_ff <= mask;
		for (n = 0; n < 8 && ok !== 1'b1; n++) begin
			@(posedge i_clk_sys);
			#1;
			ok = (i_status_word1[ans] === 1'b1);
		end
		@(posedge i_clk_sys);
		req_ff <= 16'h0000;
		for (n = 0; n < 8 && i_status_word1[ans] !== 1'b0; n++) begin
			@(posedge i_clk_sys);
			#1;
		end
		ok = ok && (i_status_word1[ans] === 1'b0);
	endtask
endmodule
`default_nettype wire

// *** tb/drive_cyclic_command_mapper_tb.sv ***
// Self-checking bench for the cyclic command mapper, driven through a controller model.
`timescale 1ns/10ps
`default_nettype none
`include "drive_map.svh"
module drive_cyclic_command_mapper_tb import drive_pkg::*; ;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic drst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ifwr = 1'b0;
	logic [15:0] ifdata = 16'h0000;
	drive_state_s dstate = '0;
	logic [15:0] rdata;
	cmd_word1_s w1;
	cmd_word2_s w2;
	logic [15:0] fw;
	drive_cmd_s dcmd;
	logic [15:0] sfreq;
	logic fspeed;
	logic nvs;
	logic erst;
	logic plc;
	logic [15:0] s1;
	logic [15:0] s2;
	int miscompares = 0;
	int samples_checked = 0;
	int nv_cnt = 0;
	int er_cnt = 0;
	logic [7:0] ext_tab [10] = '{`EXT_0, `EXT_1, `EXT_12, `EXT_14, `EXT_18,
		`EXT_100, `EXT_112, `EXT_114, `EXT_118, 8'h05};

	always #25 clk = ~clk;

	always @(posedge clk) begin
		if (nvs === 1'b1) nv_cnt++;
		if (erst === 1'b1) er_cnt++;
	end

	fieldbus_master_model u_fieldbus_master_model (
		.i_clk_sys(clk), .i_status_word1(s1), .o_cmd_word1(w1), .o_cmd_word2(w2),
		.o_frequency_command_word(fw));

	drive_cyclic_command_mapper u_drive_cyclic_command_mapper (
		.i_clk_sys(clk), .i_nrst(nrst), .i_drive_reset(drst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_cmd_word1(w1), .i_cmd_word2(w2), .i_frequency_command_word(fw),
		.i_instr_freq_wr(ifwr), .i_instr_freq_data(ifdata), .i_drive_state(dstate),
		.o_drive_cmd(dcmd), .o_set_freq(sfreq), .o_freq_is_speed(fspeed), .o_nv_store(nvs),
		.o_error_reset(erst), .o_plc_enable(plc), .o_status_word1(s1), .o_status_word2(s2));

	function automatic drive_cmd_s exp_cmd(input logic [15:0] a, input logic [15:0] b,
		input logic sw);
		drive_cmd_s e;
		e.run_forward = sw ? a[1] : a[0];
		e.run_reverse = sw ? a[0] : a[1];
		e.high_speed_select = a[2];
		e.middle_speed_select = a[3];
		e.low_speed_select = a[4];
		e.jog_select = a[5];
		e.second_function = a[6];
		e.current_input_sel = a[7];
		e.output_stop = a[9];
		e.assignable_reset_function = a[11];
		e.assignable_input = {b[13], b[12], b[11], a[10], a[8]};
		return e;
	endfunction

	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic pulse_reset();
		@(posedge clk);
		drst <= 1'b1;
		@(posedge clk);
		drst <= 1'b0;
		settle();
	endtask

	// A handshake that never completes ends the run at once.
	task automatic hs(input logic [15:0] mask, input int ans);
		logic ok;
		u_fieldbus_master_model.request(mask, ans, ok);
		cmp1(ok, 1'b1);
		if (ok !== 1'b1) print_verdict();
	endtask

	task automatic err_clear();
		u_fieldbus_master_model.set_words(16'h0000, 16'h0400, 16'h0000);
		settle();
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'h0000);
		settle();
	endtask

	initial begin
		logic [15:0] v;
		logic [15:0] e1;
		logic [15:0] e2;
		logic ok;
		int p;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(`ADDR_CFG, v);
		cmp16(v, `CFG_RST);
		rd_reg(`ADDR_ACTIVE, v);
		cmp16(v, 16'h0100);
		rd_reg(`ADDR_FREQ, v);
		cmp16(v, `FREQ_RST);
		rd_reg(4'hF, v);
		cmp16(v, 16'h0000);
		for (p = 0; p < 16; p++) begin
			e1 = (p > 3) ? 16'(1 << (15 - p)) : 16'h0000;
			e2 = (p == 3) ? 16'h0040 : (p == 2) ? 16'h0080 : (p == 1) ? 16'h0400 :
				(p == 0) ? 16'h0800 : 16'h0000;
			@(posedge clk);
			dstate <= drive_state_s'(16'(1 << p));
			settle();
			cmp16(s1, e1);
			cmp16(s2, e2);
		end
		@(posedge clk);
		dstate <= '0;
		for (p = 0; p < 15; p++) begin
			e1 = (p < 12) ? 16'(1 << p) : 16'h0000;
			e2 = (p < 12) ? 16'hC3FF : 16'(1 << (p - 1));
			u_fieldbus_master_model.set_words(e1, e2, 16'h0000);
			settle();
			cmp16(16'(dcmd), 16'(exp_cmd(e1, e2, 1'b0)));
		end
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'h03E8);
		hs(16'h2000, 13);
		rd_reg(`ADDR_FREQ, v);
		cmp16(v, 16'h03E8);
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, `FREQ_MAX_HZ);
		hs(16'h4000, 14);
		cmp16(sfreq, `FREQ_MAX_HZ);
		cmp16(16'(nv_cnt), 16'h0001);
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'hE679);
		u_fieldbus_master_model.request(16'h2000, 13, ok);
		cmp1(ok, 1'b1);
		cmp16(sfreq, `FREQ_MAX_HZ);
		cmp1(s2[10], 1'b1);
		err_clear();
		cmp16(16'(er_cnt), 16'h0001);
		cmp1(s2[10], 1'b0);
		wr_reg(`ADDR_CFG, 16'h0100);
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'hFC18);
		hs(16'h2000, 13);
		cmp16(sfreq, 16'h03E8);
		for (p = 1; p < 3; p++) begin
			u_fieldbus_master_model.set_words(16'(p), 16'h0000, 16'hFC18);
			settle();
			cmp16(16'(dcmd), 16'(exp_cmd(16'(p), 16'h0000, 1'b1)));
		end
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'h0064);
		hs(16'h4000, 14);
		cmp16(sfreq, 16'h03E8);
		rd_reg(`ADDR_STAT, v);
		cmp16(v, 16'h0103);
		cmp1(s2[10], 1'b1);
		err_clear();
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'h0064);
		hs(16'h6000, 13);
		cmp16(sfreq, 16'h0064);
		cmp16(16'(nv_cnt), 16'h0001);
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'hFC18);
		hs(16'h2000, 13);
		@(posedge clk);
		ifwr <= 1'b1;
		ifdata <= 16'h01F4;
		@(posedge clk);
		ifwr <= 1'b0;
		settle();
		cmp16(sfreq, 16'h01F4);
		rd_reg(`ADDR_STAT, v);
		cmp16(v & 16'h0001, 16'h0001);
		pulse_reset();
		cmp16(sfreq, 16'h0000);
		rd_reg(`ADDR_STAT, v);
		cmp16(v & 16'h0001, 16'h0000);
		wr_reg(`ADDR_CFG, 16'h0200);
		u_fieldbus_master_model.set_words(16'h0000, 16'h0000, 16'hFFFF);
		hs(16'h2000, 13);
		cmp16(sfreq, 16'hFFFF);
		cmp1(fspeed, 1'b1);
		hs(16'h1000, 12);
		hs(16'h8000, 15);
		wr_reg(`ADDR_CFG, 16'h0070);
		rd_reg(`ADDR_ACTIVE, v);
		cmp16(v, 16'h0100);
		for (p = 0; p < 10; p++) begin
			wr_reg(`ADDR_CFG, {8'h00, ext_tab[p]});
			pulse_reset();
			rd_reg(`ADDR_ACTIVE, v);
			cmp16(v, {6'h00, p > 4 && p < 9, p < 9, ext_tab[p]});
			cmp1(plc, p > 4 && p < 9);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
